// *** rtl/pllsr_device.sv ***
// synthesizer end: status registers, indirect oscillator access and block enables
`include "pllsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pllsr_device (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial link
    pllsr_if.device link,
    // loop status from the analog side
    input wire logic [18:0] phase_error_magnitude,
    input wire logic phase_error_polarity,
    input wire logic gpo_level,
    input wire logic lock_detect,
    input wire logic [15:0] self_test_signature,
    input wire logic self_test_running,
    // oscillator controls
    output logic cal_voltage_select,
    output logic [7:0] oscillator_sub_band,
    output logic osc_core_en,
    output logic pll_buf_en,
    output logic rf_buf_en,
    output logic div1_en,
    output logic rf_div_en,
    output logic rf_mute,
    // self-test verdict
    output logic self_test_pass
);
    // ****************************************************************
    // pin synchronisation and edge detection
    // ****************************************************************
    logic sck_s;
    logic sen_s;
    logic sdi_s;
    logic sck_q;
    logic sen_q;

    pllsr_sync #(.W(3)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({link.sck, link.sen, link.sdi}),
        .q({sck_s, sen_s, sdi_s})
    );

    // previous synchronised levels for edge finding
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            sen_q <= 1'b0;
        end else begin
            sck_q <= sck_s;
            sen_q <= sen_s;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    assign sck_rise = sck_s & ~sck_q;
    assign sck_fall = ~sck_s & sck_q;
    assign frame_end = sen_q & ~sen_s;

    // ****************************************************************
    // frame receiver
    // ****************************************************************
    logic [4:0] bit_cnt_q;
    logic [30:0] shift_in_q;

    // bits are taken on the rising serial clock; count saturates at a full frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 5'h00;
            shift_in_q <= '0;
        end else if (!sen_s) begin
            bit_cnt_q <= 5'h00;
        end else if (sck_rise) begin
            shift_in_q <= {shift_in_q[29:0], sdi_s};
            if (bit_cnt_q != 5'(`PLLSR_FRAME_BITS)) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // header is the first seven bits; once the frame is full it sits above the data
    logic hdr_read;
    logic [5:0] hdr_addr;
    logic frame_full;
    logic [23:0] frame_data;
    assign hdr_read = (bit_cnt_q == 5'(`PLLSR_HDR_BITS)) ? shift_in_q[6] : shift_in_q[30];
    assign hdr_addr = shift_in_q[29:24];
    assign frame_full = (bit_cnt_q == 5'(`PLLSR_FRAME_BITS));
    assign frame_data = shift_in_q[23:0];

    // ****************************************************************
    // status registers: sampled every cycle, never written by the host
    // ****************************************************************
    logic [23:0] phase_err_q;
    logic [23:0] out_lock_q;
    logic [23:0] self_test_q;

    // capture from the loop; no host path reaches these flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_err_q <= `PLLSR_PHASE_ERR_RST;
            out_lock_q <= `PLLSR_OUT_LOCK_RST;
            self_test_q <= `PLLSR_SELF_TEST_RST;
        end else begin
            phase_err_q <= {4'h0, phase_error_polarity, phase_error_magnitude};
            out_lock_q <= {22'h000000, lock_detect, gpo_level};
            self_test_q <= {7'h00, self_test_running, self_test_signature};
        end
    end

    // verdict only once the run is over, so a half-built signature never passes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            self_test_pass <= 1'b0;
        end else begin
            self_test_pass <= ~self_test_q[`PLLSR_ST_RUN_BIT]
                & (self_test_q[15:0] == `PLLSR_ST_SIG_EXPECTED);
        end
    end

    // ****************************************************************
    // read path: data goes out on the falling serial clock
    // ****************************************************************
    logic [23:0] read_word;
    logic [23:0] shift_out_q;

    // indirect register is write-only and reads as zero, like unmapped offsets
    always_comb begin
        case (shift_in_q[5:0])
            `PLLSR_REG_PHASE_ERR: read_word = phase_err_q;
            `PLLSR_REG_OUT_LOCK: read_word = out_lock_q;
            `PLLSR_REG_SELF_TEST: read_word = self_test_q;
            default: read_word = 24'h000000;
        endcase
    end

    // load after the header, then shift once per falling edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_out_q <= '0;
            link.sdo_oe_n <= 1'b1;
        end else if (!sen_s) begin
            link.sdo_oe_n <= 1'b1;
        end else if (sck_fall) begin
            // the read flag is only in bit 6 right after the header; the drive enable keeps it
            if (bit_cnt_q == 5'(`PLLSR_HDR_BITS) && hdr_read) begin
                shift_out_q <= read_word;
                link.sdo_oe_n <= 1'b0;
            end else if (!link.sdo_oe_n) begin
                shift_out_q <= {shift_out_q[22:0], 1'b0};
            end
        end
    end

    assign link.sdo_drv = shift_out_q[23];

    // ****************************************************************
    // indirect oscillator access
    // ****************************************************************
    logic commit;
    logic [2:0] ind_id;
    logic [3:0] ind_sub;
    logic [8:0] ind_data;
    // only a whole write frame to the indirect register reaches the subsystem
    assign commit = frame_end & frame_full & ~hdr_read
        & (hdr_addr == `PLLSR_REG_INDIRECT);
    assign ind_id = frame_data[`PLLSR_IND_ID_LSB +: 3];
    assign ind_sub = frame_data[`PLLSR_IND_SUB_LSB +: 4];
    assign ind_data = frame_data[`PLLSR_IND_DATA_LSB +: 9];

    logic [8:0] tuning_q;
    logic [8:0] enables_q;
    logic [5:0] rf_ratio_q;
    logic manual_q;

    // whole subregister replaced on every write, since nothing can be read back
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tuning_q <= `PLLSR_TUNING_RST;
            enables_q <= `PLLSR_ENABLES_RST;
            rf_ratio_q <= `PLLSR_RF_RATIO_RST;
            manual_q <= 1'b0;
        end else if (commit && ind_id == `PLLSR_OSC_ID) begin
            case (ind_sub)
                `PLLSR_OSC_TUNING: tuning_q <= ind_data;
                `PLLSR_OSC_ENABLES: enables_q <= ind_data;
                `PLLSR_OSC_BIASES: rf_ratio_q <= ind_data[5:0];
                `PLLSR_OSC_CONFIG: manual_q <= ind_data[`PLLSR_CFG_MANUAL_BIT];
                default: manual_q <= manual_q;
            endcase
        end
    end

    // ****************************************************************
    // block enables
    // ****************************************************************
    logic master;
    logic auto_buf;
    logic auto_div1;
    logic auto_div;
    assign master = enables_q[0];
    // automatic mode follows the divide ratio: 0 mutes, 1 is undivided, more divides
    assign auto_buf = (rf_ratio_q != 6'h00);
    assign auto_div1 = (rf_ratio_q == 6'h01);
    assign auto_div = (rf_ratio_q > 6'h01);

    // outputs registered so the analog controls never glitch; bits 8:5 unused
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_voltage_select <= 1'b0;
            oscillator_sub_band <= 8'h10;
            osc_core_en <= 1'b0;
            pll_buf_en <= 1'b0;
            rf_buf_en <= 1'b0;
            div1_en <= 1'b0;
            rf_div_en <= 1'b0;
            rf_mute <= 1'b1;
        end else begin
            cal_voltage_select <= tuning_q[0];
            oscillator_sub_band <= tuning_q[8:1];
            osc_core_en <= master;
            if (manual_q) begin
                pll_buf_en <= master & enables_q[1];
                rf_buf_en <= master & enables_q[2];
                div1_en <= master & enables_q[3];
                rf_div_en <= master & enables_q[4];
                rf_mute <= ~(master & enables_q[2]);
            end else begin
                pll_buf_en <= master;
                rf_buf_en <= master & auto_buf;
                div1_en <= master & auto_div1;
                rf_div_en <= master & auto_div;
                rf_mute <= ~(master & auto_buf);
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/pllsr_defs.svh ***
// register offsets, field positions, reset values and timing counts of the synthesizer port
`ifndef PLLSR_DEFS_SVH
`define PLLSR_DEFS_SVH

// ****************************************************************
// serial frame layout: read flag, 6-bit address, 24-bit data, MSB first
// ****************************************************************
`define PLLSR_FRAME_BITS 31
`define PLLSR_HDR_BITS 7
`define PLLSR_ADDR_W 6
`define PLLSR_DATA_W 24

// ****************************************************************
// host register offsets
// ****************************************************************
`define PLLSR_REG_INDIRECT 6'h05
`define PLLSR_REG_PHASE_ERR 6'h11
`define PLLSR_REG_OUT_LOCK 6'h12
`define PLLSR_REG_SELF_TEST 6'h13

// ****************************************************************
// status register reset values and field positions
// ****************************************************************
`define PLLSR_PHASE_ERR_RST 24'h007FFF
`define PLLSR_OUT_LOCK_RST 24'h000000
`define PLLSR_SELF_TEST_RST 24'h000000
`define PLLSR_PE_POL_BIT 19
`define PLLSR_GPO_BIT 0
`define PLLSR_LOCK_BIT 1
`define PLLSR_ST_RUN_BIT 16
`define PLLSR_ST_SIG_EXPECTED 16'h1259

// ****************************************************************
// indirect word fields
// ****************************************************************
`define PLLSR_IND_ID_LSB 0
`define PLLSR_IND_SUB_LSB 3
`define PLLSR_IND_DATA_LSB 7
`define PLLSR_OSC_ID 3'h0

// ****************************************************************
// oscillator subregisters and reset values
// ****************************************************************
`define PLLSR_OSC_TUNING 4'h0
`define PLLSR_OSC_ENABLES 4'h1
`define PLLSR_OSC_BIASES 4'h2
`define PLLSR_OSC_CONFIG 4'h3
`define PLLSR_TUNING_RST 9'h020
`define PLLSR_ENABLES_RST 9'h01F
`define PLLSR_RF_RATIO_RST 6'h01
`define PLLSR_CFG_MANUAL_BIT 2

// ****************************************************************
// timing: serial clock made by the host from the core clock
// ****************************************************************
`define PLLSR_CORE_PERIOD_NS 8
`define PLLSR_SCK_PERIOD_NS 80
`define PLLSR_SCK_HALF_CYC ((`PLLSR_SCK_PERIOD_NS / 2) / `PLLSR_CORE_PERIOD_NS)

`endif

// *** rtl/pllsr_pkg.sv ***
// types used by the host end of the synthesizer serial port
package pllsr_pkg;
    // host shift engine states
    typedef enum logic [2:0] {
        HOST_IDLE = 3'b001,
        HOST_SHIFT = 3'b010,
        HOST_DONE = 3'b100
    } pllsr_host_state_type;
endpackage

// *** rtl/pllsr_if.sv ***
// serial link between host controller and synthesizer register bank
`timescale 1ns/1ps
`default_nettype none
interface pllsr_if;
    logic sck;
    logic sen;
    logic sdi;
    logic sdo_drv;
    logic sdo_oe_n;
    logic sdo;

    // a weak pull holds the data-out wire low while the device does not drive it
    assign sdo = sdo_oe_n ? 1'b0 : sdo_drv;

    modport device (input sck, input sen, input sdi, output sdo_drv, output sdo_oe_n);
    modport host (output sck, output sen, output sdi, input sdo);
endinterface
`default_nettype wire

// *** rtl/pllsr_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pllsr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** rtl/pllsr_host.sv ***
// host end: builds serial frames, makes the serial clock, returns read data
`include "pllsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pllsr_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial link
    pllsr_if.host link,
    // direct register command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [5:0] cmd_addr,
    input wire logic [23:0] cmd_wdata,
    // oscillator subregister command
    input wire logic osc_valid,
    output logic osc_ready,
    input wire logic [3:0] osc_reg,
    input wire logic [8:0] osc_data,
    // completion
    output logic rsp_valid,
    output logic [23:0] rsp_rdata
);
    // ****************************************************************
    // command acceptance
    // ****************************************************************
    pllsr_pkg::pllsr_host_state_type state_q;
    logic sdo_s;
    logic [30:0] frame_q;
    logic [4:0] bit_idx_q;
    logic [2:0] half_cnt_q;
    logic is_read_q;
    logic [23:0] rx_q;
    logic [23:0] osc_word;

    // direct commands win over oscillator writes
    assign cmd_ready = (state_q == pllsr_pkg::HOST_IDLE);
    assign osc_ready = (state_q == pllsr_pkg::HOST_IDLE) & ~cmd_valid;
    // caller supplies all nine bits, unchanged ones included
    assign osc_word = {8'h00, osc_data, osc_reg, `PLLSR_OSC_ID};

    pllsr_sync #(.W(1)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d(link.sdo),
        .q(sdo_s)
    );

    // ****************************************************************
    // shift engine
    // ****************************************************************
    // sample late in the high phase to cover the device's sync delay
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pllsr_pkg::HOST_IDLE;
            frame_q <= '0;
            bit_idx_q <= 5'h00;
            half_cnt_q <= 3'h0;
            is_read_q <= 1'b0;
            rx_q <= '0;
            link.sck <= 1'b0;
            link.sen <= 1'b0;
            link.sdi <= 1'b0;
        end else begin
            case (state_q)
                pllsr_pkg::HOST_IDLE: begin
                    half_cnt_q <= 3'h0;
                    bit_idx_q <= 5'h00;
                    if (cmd_valid) begin
                        frame_q <= {cmd_read, cmd_addr, cmd_wdata};
                        link.sdi <= cmd_read;
                        is_read_q <= cmd_read;
                        link.sen <= 1'b1;
                        state_q <= pllsr_pkg::HOST_SHIFT;
                    end else if (osc_valid) begin
                        frame_q <= {1'b0, `PLLSR_REG_INDIRECT, osc_word};
                        link.sdi <= 1'b0;
                        is_read_q <= 1'b0;
                        link.sen <= 1'b1;
                        state_q <= pllsr_pkg::HOST_SHIFT;
                    end
                end
                pllsr_pkg::HOST_SHIFT: begin
                    if (half_cnt_q != 3'(`PLLSR_SCK_HALF_CYC - 1)) begin
                        half_cnt_q <= half_cnt_q + 3'h1;
                    end else begin
                        half_cnt_q <= 3'h0;
                        if (!link.sck) begin
                            link.sck <= 1'b1;
                        end else begin
                            link.sck <= 1'b0;
                            rx_q <= {rx_q[22:0], sdo_s};
                            frame_q <= {frame_q[29:0], 1'b0};
                            link.sdi <= frame_q[29];
                            if (bit_idx_q == 5'(`PLLSR_FRAME_BITS - 1)) begin
                                state_q <= pllsr_pkg::HOST_DONE;
                            end else begin
                                bit_idx_q <= bit_idx_q + 5'h01;
                            end
                        end
                    end
                end
                pllsr_pkg::HOST_DONE: begin
                    link.sen <= 1'b0;
                    link.sdi <= 1'b0;
                    state_q <= pllsr_pkg::HOST_IDLE;
                end
                default: state_q <= pllsr_pkg::HOST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // completion report
    // ****************************************************************
    // one pulse per frame; read data held until the next read ends
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= (state_q == pllsr_pkg::HOST_DONE);
            if (state_q == pllsr_pkg::HOST_DONE && is_read_q) begin
                rsp_rdata <= rx_q;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/pllsr_link_asserts.sv ***
// concurrent checks on the serial link between host and synthesizer ends
`timescale 1ns/1ps
`default_nettype none
module pllsr_link_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link signals
    input wire logic sck,
    input wire logic sen,
    input wire logic sdi,
    input wire logic sdo_drv,
    input wire logic sdo_oe_n,
    input wire logic sdo
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic sck_q;
    logic [5:0] rises_q;
    logic rd_q;

    // ****************************************************************
    // helper logic
    // ****************************************************************
    // one cycle of serial clock history for edge finding
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
        end
    end

    // rising edges in this frame; the first bit carries the read flag
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rises_q <= 6'h00;
            rd_q <= 1'b0;
        end else if (!sen) begin
            rises_q <= 6'h00;
        end else if (sck && !sck_q) begin
            rises_q <= rises_q + 6'h01;
            if (rises_q == 6'h00) begin
                rd_q <= sdi;
            end
        end
    end

    // ****************************************************************
    // link checks
    // ****************************************************************
    sequence s_high_phase;
        sck [*5] ##1 !sck;
    endsequence
    sequence s_low_phase;
        (!sck) [*5];
    endsequence

    a_sck_idle_low: assert property (!sen |-> !sck)
        else $error("serial clock high outside a frame");
    a_sck_high_phase: assert property ($rose(sck) |-> s_high_phase)
        else $error("serial clock high phase not five cycles");
    a_sck_low_phase: assert property ($fell(sck) |-> s_low_phase)
        else $error("serial clock low phase too short");
    a_sdi_held_high: assert property (sck && sck_q |-> $stable(sdi))
        else $error("host data moved while serial clock high");
    a_frame_bit_count: assert property ($fell(sen) |-> rises_q == 6'h1F)
        else $error("frame did not carry 31 bits");
    a_drive_after_hdr: assert property ($fell(sdo_oe_n) |-> sen && !sck && rises_q == 6'h07)
        else $error("device began driving at the wrong bit");
    a_drive_read_only: assert property (!sdo_oe_n |-> rd_q)
        else $error("device drove data during a write frame");
    a_drive_release: assert property ($fell(sen) |-> ##[1:4] sdo_oe_n)
        else $error("device kept driving after frame end");
    a_idle_no_drive: assert property ((!sen) [*4] |-> sdo_oe_n)
        else $error("device drove data between frames");
    a_sdo_held_high: assert property (!sdo_oe_n && sck && sck_q |->
        $stable(sdo_drv) && $stable(sdo))
        else $error("device data moved while serial clock high");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench: host and synthesizer ends joined by the serial link
`include "pllsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk, rst_n;
    logic cmd_valid, cmd_ready, cmd_read, osc_valid, osc_ready, rsp_valid;
    logic [5:0] cmd_addr;
    logic [23:0] cmd_wdata, rsp_rdata;
    logic [3:0] osc_reg;
    logic [8:0] osc_data;
    logic [18:0] pe_mag;
    logic [15:0] st_sig;
    logic pe_pol, gpo_level, lock_detect, st_run, st_pass, cal_sel;
    logic [7:0] sub_band;
    logic core_en, pll_en, rf_en, div1_en, rfdiv_en, mute;
    int n_errors, cmp_count, cycles;
    logic [8:0] man_tab [5] = '{9'h01B, 9'h1F5, 9'h01E, 9'h01F, 9'h1E3};

    pllsr_if link_if();
    pllsr_device i_pllsr_device (.core_clk(core_clk), .rst_n(rst_n), .link(link_if),
        .phase_error_magnitude(pe_mag), .phase_error_polarity(pe_pol), .gpo_level(gpo_level),
        .lock_detect(lock_detect), .self_test_signature(st_sig), .self_test_running(st_run),
        .cal_voltage_select(cal_sel), .oscillator_sub_band(sub_band), .osc_core_en(core_en),
        .pll_buf_en(pll_en), .rf_buf_en(rf_en), .div1_en(div1_en), .rf_div_en(rfdiv_en),
        .rf_mute(mute), .self_test_pass(st_pass));
    pllsr_host i_pllsr_host (.core_clk(core_clk), .rst_n(rst_n), .link(link_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .osc_valid(osc_valid), .osc_ready(osc_ready), .osc_reg(osc_reg),
        .osc_data(osc_data), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    pllsr_link_asserts i_pllsr_link_asserts (.core_clk(core_clk), .rst_n(rst_n),
        .sck(link_if.sck), .sen(link_if.sen), .sdi(link_if.sdi), .sdo_drv(link_if.sdo_drv),
        .sdo_oe_n(link_if.sdo_oe_n), .sdo(link_if.sdo));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one whole command; the caller always passes every bit of the word
    task automatic xfer(input logic osc, input logic rd, input logic [5:0] a, input logic [23:0] wd);
        int n;
        n = 0;
        @(negedge core_clk);
        check("ready", {23'h0, osc ? osc_ready : cmd_ready}, 24'h000001);
        cmd_read = rd;
        cmd_addr = a;
        cmd_wdata = wd;
        osc_reg = a[3:0];
        osc_data = wd[8:0];
        cmd_valid = !osc;
        osc_valid = osc;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        osc_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check("rsp_valid", {23'h0, rsp_valid}, 24'h000001);
        // device outputs follow about four cycles after frame end
        repeat (8) @(negedge core_clk);
    endtask

    task automatic check_en(input logic [5:0] e);
        check("enables", {18'h0, core_en, pll_en, rf_en, div1_en, rfdiv_en, mute}, {18'h0, e});
    endtask

    function automatic logic [5:0] man_exp(input logic [8:0] e);
        return {e[0], e[0] & e[1], e[0] & e[2], e[0] & e[3], e[0] & e[4], !(e[0] & e[2])};
    endfunction

    task automatic close_out();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // status fields, with every read-only register hit by an all-ones write first
    task automatic t_status();
        for (int i = 0; i < 2; i++) begin
            pe_mag = (i == 1) ? 19'h7FFFF : 19'h2A5A5;
            pe_pol = (i == 1);
            gpo_level = (i == 1);
            lock_detect = (i == 0);
            st_sig = 16'h1259;
            st_run = (i == 0);
            for (int a = 0; a < 3; a++) begin
                xfer(1'b0, 1'b0, `PLLSR_REG_PHASE_ERR + a[5:0], 24'hFFFFFF);
            end
            xfer(1'b0, 1'b1, `PLLSR_REG_PHASE_ERR, 24'h000000);
            check("phase_err", rsp_rdata, {4'h0, pe_pol, pe_mag});
            xfer(1'b0, 1'b1, `PLLSR_REG_OUT_LOCK, 24'h000000);
            check("out_lock", rsp_rdata, {22'h0, lock_detect, gpo_level});
            xfer(1'b0, 1'b1, `PLLSR_REG_SELF_TEST, 24'h000000);
            check("self_test", rsp_rdata, {7'h0, st_run, st_sig});
            check("st_pass", {23'h0, st_pass}, {23'h0, (i == 1)});
        end
        xfer(1'b0, 1'b1, `PLLSR_REG_INDIRECT, 24'h000000);
        check("indirect_read", rsp_rdata, 24'h000000);
        xfer(1'b0, 1'b1, 6'h3A, 24'h000000);
        check("unmapped_read", rsp_rdata, 24'h000000);
    endtask

    // tuning subregister through the indirect word and the host helper
    task automatic t_tuning();
        check("tuning_rst", {15'h0, sub_band, cal_sel}, 24'h000020);
        xfer(1'b0, 1'b0, `PLLSR_REG_INDIRECT, {8'hFF, 9'h14B, 4'h0, 3'h0});
        check("tuning", {15'h0, sub_band, cal_sel}, 24'h00014B);
        xfer(1'b0, 1'b0, `PLLSR_REG_INDIRECT, {8'h00, 9'h000, 4'h0, 3'h2});
        check("wrong_id", {15'h0, sub_band, cal_sel}, 24'h00014B);
        xfer(1'b1, 1'b0, 6'h04, 24'h000000);
        check("other_sub", {15'h0, sub_band, cal_sel}, 24'h00014B);
        xfer(1'b1, 1'b0, 6'h00, 24'h0001FE);
        check("lowest_band", {15'h0, sub_band, cal_sel}, 24'h0001FE);
    endtask

    // block enables in automatic then manual output mode
    task automatic t_enables();
        check_en(6'b111100);
        xfer(1'b1, 1'b0, 6'h01, 24'h000001);
        check_en(6'b111100);
        xfer(1'b1, 1'b0, 6'h02, 24'h000000);
        check_en(6'b110001);
        xfer(1'b1, 1'b0, 6'h02, 24'h00003E);
        check_en(6'b111010);
        xfer(1'b1, 1'b0, 6'h01, 24'h000000);
        check_en(6'b000001);
        xfer(1'b1, 1'b0, 6'h03, 24'h000004);
        for (int k = 0; k < 5; k++) begin
            xfer(1'b1, 1'b0, 6'h01, {15'h0, man_tab[k]});
            check_en(man_exp(man_tab[k]));
        end
    endtask

    // ****************************************************************
    // clock, main sequence and hang guard
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        {rst_n, cmd_valid, cmd_read, osc_valid, pe_pol, gpo_level, lock_detect, st_run} = 8'h00;
        cmd_addr = 6'h00;
        cmd_wdata = 24'h000000;
        osc_reg = 4'h0;
        osc_data = 9'h000;
        pe_mag = 19'h00000;
        st_sig = 16'h0000;
        n_errors = 0;
        cmp_count = 0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        t_enables();
        t_tuning();
        t_status();
        close_out();
    end

    // about 30 transfers of some 330 cycles each are expected
    initial cycles = 0;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end
endmodule
`default_nettype wire
